// *** logic/jrii_pkg.sv ***
// Constants, opcodes and state types of the JTAG RAM init interface.
// Assumes a single 125 MHz system clock; the TAP macro runs on its own TCK.
package jrii_pkg;

    // System clock
    localparam int CLK_PERIOD_PS = 8000;

    // Least times around the RAM write clock edge
    localparam int WR_SETUP_NS     = 16;
    localparam int WR_HOLD_NS      = 8;
    localparam int WR_SETUP_CYCLES = (WR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WR_HOLD_CYCLES  = (WR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PHASE_CNT_W     = 4;

    // Default sizes
    localparam int DEF_IR_W       = 8;
    localparam int DEF_DATA_W     = 8;
    localparam int DEF_ADDR_W     = 8;
    localparam int DEF_NUM_BLOCKS = 4;

    // User opcodes; values are free for the user to pick
    localparam logic [DEF_IR_W-1:0] START_OPCODE      = 8'h10;
    localparam logic [DEF_IR_W-1:0] BLOCK_OPCODE_BASE = 8'h20;

    // Reset values
    localparam logic RAM_WCLK_IDLE_RISE = 1'h1;

    typedef enum {
        OUT_IDLE,
        OUT_SETUP,
        OUT_HOLD
    } jrii_out_state_type;

endpackage

// *** logic/jrii_stream_if.sv ***
// Valid/ready word stream between the loader and its buffer.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface jrii_stream_if #(
    parameter int W = 8
) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

// *** logic/jrii_pair_buffer.sv ***
// Two-entry word buffer with honest full and empty.
// Assumes one clock; the drain side may stall at will.
`timescale 1ns/100ps
module jrii_pair_buffer #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Streams
    jrii_stream_if.sink     in_s,
    jrii_stream_if.source   out_s
);
    logic [W-1:0] slot [2];
    logic         rd_ptr;
    logic         wr_ptr;
    logic [1:0]   count;
    logic [1:0]   next_count;
    logic         not_full;
    wire          push = in_s.valid & not_full;
    wire          pop  = out_s.valid & out_s.ready;

    assign in_s.ready  = not_full;
    assign out_s.valid = (count != 2'h0);
    assign out_s.data  = slot[rd_ptr];
    assign next_count  = (push && !pop) ? count + 2'h1 :
                         (pop && !push) ? count - 2'h1 : count;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count    <= 2'h0;
            rd_ptr   <= 1'b0;
            wr_ptr   <= 1'b0;
            not_full <= 1'b1;
        end else begin
            count    <= next_count;
            not_full <= (next_count != 2'h2);
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            slot[wr_ptr] <= in_s.data;
        end
    end
endmodule

// *** logic/jrii_loader.sv ***
// JTAG RAM init interface: turns user data scans into RAM writes.
// Assumes clk is well over three times TCK, and that the instruction
// register stays steady while data words are scanned.
`timescale 1ns/100ps
module jrii_loader
    import jrii_pkg::*;
#(
    parameter int IR_W           = DEF_IR_W,
    parameter int DATA_W         = DEF_DATA_W,
    parameter int ADDR_W         = DEF_ADDR_W,
    parameter int NUM_BLOCKS     = DEF_NUM_BLOCKS,
    parameter bit RAM_FALL_WRITE = 1'b0
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // TAP macro user access
    input  wire logic                  tap_tck,
    input  wire logic                  tap_tdi,
    input  wire logic                  shift_state_strobe,
    input  wire logic                  update_state_strobe,
    input  wire logic [IR_W-1:0]       user_instr_value,
    // Options
    input  wire logic                  broadcast_all,
    // RAM side
    input  wire logic                  ram_ready,
    output logic      [ADDR_W-1:0]     ram_addr,
    output logic      [DATA_W-1:0]     ram_wdata,
    output logic      [NUM_BLOCKS-1:0] ram_wen,
    output logic                       ram_wclk,
    // Status
    output logic                       load_ready,
    output logic                       data_overrun,
    output logic                       init_active
);
    localparam int SYNC_W = IR_W + 5;
    localparam int PAY_W  = NUM_BLOCKS + ADDR_W + DATA_W;
    localparam logic [ADDR_W-1:0] LAST_ADDR = '1;
    localparam logic [PHASE_CNT_W-1:0] SETUP_CNT = PHASE_CNT_W'(WR_SETUP_CYCLES - 1);
    localparam logic [PHASE_CNT_W-1:0] HOLD_CNT  = PHASE_CNT_W'(WR_HOLD_CYCLES - 1);

    // Two-stage input synchronisers
    logic [SYNC_W-1:0]     sync_meta;
    logic [SYNC_W-1:0]     sync_out;
    logic                  tck_prev;
    logic                  upd_prev;
    logic [IR_W-1:0]       ir_prev;

    // Load path
    logic [DATA_W-1:0]     shreg;
    logic [ADDR_W-1:0]     addr_cnt;
    logic [NUM_BLOCKS-1:0] ring_sel;

    // Output stage
    jrii_out_state_type    out_state;
    jrii_out_state_type    next_out_state;
    logic [PHASE_CNT_W-1:0] phase_cnt;
    logic [NUM_BLOCKS-1:0] wen_mask;

    jrii_stream_if #(.W(PAY_W)) load_s ();
    jrii_stream_if #(.W(PAY_W)) drain_s ();

    // Synchronised views
    wire                  tck_s   = sync_out[0];
    wire                  tdi_s   = sync_out[1];
    wire                  shift_s = sync_out[2];
    wire                  upd_s   = sync_out[3];
    wire                  bcast_s = sync_out[4];
    wire [IR_W-1:0]       ir_s    = sync_out[SYNC_W-1:5];

    // Event and mode decode
    wire                  tck_rise     = tck_s & ~tck_prev;
    wire                  upd_rise     = upd_s & ~upd_prev;
    wire                  start_match  = (ir_s == START_OPCODE[IR_W-1:0]);
    wire [NUM_BLOCKS-1:0] block_match;
    wire                  any_block    = |block_match;
    wire                  load_mode    = start_match | any_block;
    wire                  ir_changed   = (ir_s != ir_prev);
    wire                  word_done    = upd_rise & load_mode;
    wire                  last_addr    = (addr_cnt == LAST_ADDR);
    wire [NUM_BLOCKS-1:0] target_sel;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BLOCKS; gi++) begin : g_block_op
            // One opcode per block picks that block alone
            assign block_match[gi] =
                (ir_s == IR_W'(BLOCK_OPCODE_BASE[IR_W-1:0] + IR_W'(gi)));
        end
    endgenerate

    // Broadcast overrides, then ring, then per-block opcode
    assign target_sel = bcast_s     ? {NUM_BLOCKS{1'b1}} :
                        start_match ? ring_sel : block_match;

    // Buffer fill side
    assign load_s.valid = word_done;
    assign load_s.data  = {target_sel, addr_cnt, shreg};

    // Buffer drain side: accept a word only when idle and the RAM is ready
    assign drain_s.ready = (out_state == OUT_IDLE) & ram_ready;

    jrii_pair_buffer #(
        .W      (PAY_W)
    ) u_pair_buffer (
        .clk    (clk),
        .rst    (rst),
        .in_s   (load_s.sink),
        .out_s  (drain_s.source)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_meta <= '0;
            sync_out  <= '0;
            tck_prev  <= 1'b0;
            upd_prev  <= 1'b0;
            ir_prev   <= '0;
        end else begin
            sync_meta <= {user_instr_value, broadcast_all, update_state_strobe,
                          shift_state_strobe, tap_tdi, tap_tck};
            sync_out  <= sync_meta;
            tck_prev  <= tck_s;
            upd_prev  <= upd_s;
            ir_prev   <= ir_s;
        end
    end

    // Serial capture, LSB first as scanned
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shreg <= '0;
        end else if (tck_rise && shift_s) begin
            shreg <= {tdi_s, shreg[DATA_W-1:1]};
        end
    end

    // Address counter and block ring
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_cnt <= '0;
        end else if (!load_mode || ir_changed) begin
            addr_cnt <= '0;
        end else if (word_done && load_s.ready) begin
            addr_cnt <= addr_cnt + ADDR_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ring_sel <= NUM_BLOCKS'(1);
        end else if (!start_match) begin
            ring_sel <= NUM_BLOCKS'(1);
        end else if (word_done && load_s.ready && last_addr && !bcast_s) begin
            // Step once the current block's last address is taken
            ring_sel <= {ring_sel[NUM_BLOCKS-2:0], ring_sel[NUM_BLOCKS-1]};
        end
    end

    // A word arriving with the buffer full cannot be held back by JTAG
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_overrun <= 1'b0;
        end else if (word_done && !load_s.ready) begin
            data_overrun <= 1'b1;
        end else if (!load_mode) begin
            data_overrun <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_ready  <= 1'b0;
            init_active <= 1'b0;
        end else begin
            load_ready  <= load_s.ready & load_mode;
            init_active <= load_mode;
        end
    end

    // Output sequence: setup with strobe phase high, then the edge
    always_comb begin
        next_out_state = out_state;
        unique case (out_state)
            OUT_IDLE: begin
                if (drain_s.valid && drain_s.ready) begin
                    next_out_state = OUT_SETUP;
                end
            end
            OUT_SETUP: begin
                if (phase_cnt == SETUP_CNT) begin
                    next_out_state = OUT_HOLD;
                end
            end
            OUT_HOLD: begin
                if (phase_cnt == HOLD_CNT) begin
                    next_out_state = OUT_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_state <= OUT_IDLE;
            phase_cnt <= '0;
        end else begin
            out_state <= next_out_state;
            phase_cnt <= (next_out_state != out_state) ? '0 : phase_cnt + PHASE_CNT_W'(1);
        end
    end

    // Word and address stand from the start of setup until idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ram_addr  <= '0;
            ram_wdata <= '0;
            wen_mask  <= '0;
        end else if (drain_s.valid && drain_s.ready) begin
            {wen_mask, ram_addr, ram_wdata} <= drain_s.data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ram_wen <= '0;
        end else if (!load_mode) begin
            ram_wen <= '0;
        end else if (next_out_state != OUT_IDLE) begin
            ram_wen <= (out_state == OUT_IDLE) ? drain_s.data[PAY_W-1 -: NUM_BLOCKS]
                                               : wen_mask;
        end else begin
            ram_wen <= '0;
        end
    end

    // Strobe phase high during setup; clock is its inverse unless the
    // RAM writes on the falling edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ram_wclk <= RAM_FALL_WRITE ? ~RAM_WCLK_IDLE_RISE : RAM_WCLK_IDLE_RISE;
        end else if (RAM_FALL_WRITE) begin
            ram_wclk <= (next_out_state == OUT_SETUP);
        end else begin
            ram_wclk <= (next_out_state != OUT_SETUP);
        end
    end
endmodule

// *** verification/jrii_loader_asserts.sv ***
// Port-level checker for the JTAG RAM init loader.
// Assumes bind into jrii_loader; sees only its ports.
`timescale 1ns/100ps
module jrii_loader_asserts
    import jrii_pkg::*;
#(
    parameter int DATA_W         = DEF_DATA_W,
    parameter int ADDR_W         = DEF_ADDR_W,
    parameter int NUM_BLOCKS     = DEF_NUM_BLOCKS,
    parameter bit RAM_FALL_WRITE = 1'b0
) (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    // RAM side and status
    input wire logic [ADDR_W-1:0]     ram_addr,
    input wire logic [DATA_W-1:0]     ram_wdata,
    input wire logic [NUM_BLOCKS-1:0] ram_wen,
    input wire logic                  ram_wclk,
    input wire logic                  load_ready,
    input wire logic                  data_overrun,
    input wire logic                  init_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic wen_any;
    logic wclk_n;
    assign wen_any = |ram_wen;
    // Folded so one set of checks serves both write edges
    assign wclk_n  = ram_wclk ^ RAM_FALL_WRITE;

    wen_idle_a: assert property (!init_active && !$past(init_active) |-> ram_wen == '0)
        else $error("write enable while no load opcode");
    wclk_low_a: assert property ($rose(wen_any) |-> !wclk_n ##1 !wclk_n ##1 wclk_n)
        else $error("write clock not low for setup then rising");
    wen_len_a: assert property ($rose(wen_any) |-> wen_any [*3] ##1 !wen_any)
        else $error("write enable not three cycles");
    block_sel_a: assert property ($onehot0(ram_wen) || ram_wen == '1)
        else $error("more than one block selected");
    word_stable_a: assert property (wen_any && $past(wen_any) |-> $stable(ram_addr) && $stable(ram_wdata))
        else $error("address or data moved during write");
    wclk_idle_a: assert property (!wen_any |-> wclk_n)
        else $error("write clock active with no enable");
    wclk_edge_a: assert property ($rose(wclk_n) |-> wen_any)
        else $error("write edge without enable");
    ready_idle_a: assert property (!init_active && !$past(init_active) |-> !load_ready && !data_overrun)
        else $error("ready or overrun with no load opcode");
endmodule

// *** verification/jrii_tap_model.sv ***
// Stand-in for the TAP user-access macro: scans words and sets the instruction.
// Assumes clk is the loader clock; TCK halves last 4 clk, stopped between frames.
`timescale 1ns/100ps
module jrii_tap_model
    import jrii_pkg::*;
(
    // System clock
    input  wire logic                clk,
    // TAP user access
    output logic                     tck,
    output logic                     tdi,
    output logic                     shift_state_strobe,
    output logic                     update_state_strobe,
    output logic [DEF_IR_W-1:0]      user_instr_value
);
    initial begin
        tck = 1'b0;
        tdi = 1'b0;
        shift_state_strobe = 1'b0;
        update_state_strobe = 1'b0;
        user_instr_value = 8'h00;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pulse_tck();
        tick(4);
        tck = 1'b1;
        tick(4);
        tck = 1'b0;
    endtask

    // Data only: the scan never carries an address
    task automatic scan_word(input logic [DEF_DATA_W-1:0] d);
        shift_state_strobe = 1'b1;
        for (int i = 0; i < DEF_DATA_W; i++) begin
            tdi = d[i];
            pulse_tck();
        end
        shift_state_strobe = 1'b0;
        // Released line shows the opposite level, not the last bit
        tdi = ~tdi;
        // Stray TCK outside shift must leave the word alone
        pulse_tck();
        tick(4);
        update_state_strobe = 1'b1;
        tick(4);
        update_state_strobe = 1'b0;
        tick(4);
    endtask

    // Held steady long enough to pass the synchronisers
    task automatic set_instr(input logic [DEF_IR_W-1:0] v);
        user_instr_value = v;
        tick(6);
    endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the JTAG RAM init loader.
// Assumes default parameters; the TAP model drives the scan side.
`timescale 1ns/100ps
module tb_top
    import jrii_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       tck, tdi, shs, ups, broadcast_all, ram_ready;
    logic [7:0] instr, ram_addr, ram_wdata, got_addr, got_data;
    logic [3:0] ram_wen, got_wen;
    logic       ram_wclk, load_ready, data_overrun, init_active, wen_q;
    logic       fall_wclk, got_wclk, got_fclk;
    int         nwr = 0;
    int         miscompares = 0;
    int         cmp_count = 0;

    initial forever #4 clk = ~clk;

    jrii_tap_model tap (.clk(clk), .tck(tck), .tdi(tdi), .shift_state_strobe(shs),
        .update_state_strobe(ups), .user_instr_value(instr));

    jrii_loader dut (.clk(clk), .rst(rst), .tap_tck(tck), .tap_tdi(tdi), .shift_state_strobe(shs),
        .update_state_strobe(ups), .user_instr_value(instr), .broadcast_all(broadcast_all),
        .ram_ready(ram_ready), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_wen(ram_wen),
        .ram_wclk(ram_wclk), .load_ready(load_ready), .data_overrun(data_overrun),
        .init_active(init_active));

    // Falling-edge RAM variant shares every input; only its clock is compared
    jrii_loader #(.RAM_FALL_WRITE(1'b1)) dut_fall (.clk(clk), .rst(rst), .tap_tck(tck), .tap_tdi(tdi),
        .shift_state_strobe(shs), .update_state_strobe(ups), .user_instr_value(instr),
        .broadcast_all(broadcast_all), .ram_ready(ram_ready), .ram_addr(), .ram_wdata(), .ram_wen(),
        .ram_wclk(fall_wclk), .load_ready(), .data_overrun(), .init_active());

    // Capture each write at its enable's first cycle
    always @(posedge clk) begin
        wen_q <= |ram_wen;
        if ((|ram_wen) && !wen_q) begin
            nwr <= nwr + 1;
            got_wen <= ram_wen;
            got_addr <= ram_addr;
            got_data <= ram_wdata;
            got_wclk <= ram_wclk;
            got_fclk <= fall_wclk;
        end
    end

    task automatic stop_test();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_wr(input int target);
        int k;
        k = 0;
        while (nwr < target && k < 60) begin
            tap.tick(1);
            k++;
        end
        if (nwr < target) begin
            miscompares++;
            $display("mismatch write_wait expected %0d seen %0d", target, nwr);
            stop_test();
        end
    endtask

    task automatic check_write(input logic [3:0] ew, input logic [7:0] ea, input logic [7:0] ed);
        chk("ram_wen", 32'(ew), 32'(got_wen));
        chk("ram_addr", 32'(ea), 32'(got_addr));
        chk("ram_wdata", 32'(ed), 32'(got_data));
        chk("ram_wclk", 32'h0, 32'(got_wclk));
        chk("fall_wclk", 32'h1, 32'(got_fclk));
    endtask

    task automatic word(input logic [7:0] d, input logic [3:0] ew, input logic [7:0] ea);
        int n0;
        n0 = nwr;
        tap.scan_word(d);
        wait_wr(n0 + 1);
        check_write(ew, ea, d);
    endtask

    task automatic do_reset();
        tap.tick(1);
        rst = 1'b1;
        tap.tick(2);
        rst = 1'b0;
        tap.tick(2);
    endtask

    task automatic s_refuse();
        int n0;
        tap.set_instr(8'h00);
        n0 = nwr;
        tap.scan_word(8'h77);
        chk("writes", 32'(n0), 32'(nwr));
        chk("init_active", 32'h0, 32'(init_active));
        tap.set_instr(START_OPCODE);
        chk("load_ready", 32'h1, 32'(load_ready));
        word(8'h11, 4'h1, 8'h00);
        word(8'h22, 4'h1, 8'h01);
        tap.set_instr(8'h00);
        tap.set_instr(START_OPCODE);
        word(8'h33, 4'h1, 8'h00);
    endtask

    task automatic s_blocks();
        for (int i = 0; i < 4; i++) begin
            tap.set_instr(BLOCK_OPCODE_BASE + 8'(i));
            word(8'h80 + 8'(i), 4'(1 << i), 8'h00);
        end
    endtask

    task automatic s_bcast();
        tap.set_instr(8'h00);
        broadcast_all = 1'b1;
        tap.set_instr(START_OPCODE);
        word(8'h99, 4'hf, 8'h00);
        word(8'h66, 4'hf, 8'h01);
        tap.set_instr(8'h00);
        broadcast_all = 1'b0;
    endtask

    // Receiver stalls: two words held, third dropped
    task automatic s_stall();
        int n0;
        do_reset();
        tap.set_instr(START_OPCODE);
        ram_ready = 1'b0;
        n0 = nwr;
        tap.scan_word(8'ha1);
        tap.scan_word(8'ha2);
        tap.scan_word(8'ha3);
        chk("load_ready", 32'h0, 32'(load_ready));
        chk("data_overrun", 32'h1, 32'(data_overrun));
        chk("writes", 32'(n0), 32'(nwr));
        ram_ready = 1'b1;
        wait_wr(n0 + 1);
        check_write(4'h1, 8'h00, 8'ha1);
        wait_wr(n0 + 2);
        check_write(4'h1, 8'h01, 8'ha2);
        tap.set_instr(8'h00);
        chk("data_overrun", 32'h0, 32'(data_overrun));
    endtask

    // Fill block 0 to its last address, then expect block 1
    task automatic s_ring();
        do_reset();
        tap.set_instr(START_OPCODE);
        for (int a = 0; a < 256; a++) begin
            word(8'(a) ^ 8'h5a, 4'h1, 8'(a));
        end
        word(8'hc3, 4'h2, 8'h00);
    endtask

    initial begin
        broadcast_all = 1'b0;
        ram_ready = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        tap.tick(2);
        s_refuse();
        s_blocks();
        s_bcast();
        s_stall();
        s_ring();
        stop_test();
    end
endmodule

bind jrii_loader jrii_loader_asserts #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .NUM_BLOCKS(NUM_BLOCKS),
    .RAM_FALL_WRITE(RAM_FALL_WRITE)) u_chk (.clk(clk), .rst(rst), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_wen(ram_wen), .ram_wclk(ram_wclk), .load_ready(load_ready),
    .data_overrun(data_overrun), .init_active(init_active));
